// >>> rtl/imt_map.vh
/*
 * constants for the two-wire bus master transaction engine: access selects,
 * field positions, reset values, result codes and bus timing.
 * assumes it is included by bare name from the engine source.
 */
`ifndef IMT_MAP_VH
`define IMT_MAP_VH

`define IMT_SEL_PTR      3'h0
`define IMT_SEL_TXD      3'h1
`define IMT_SEL_RXD      3'h2
`define IMT_SEL_CFG      3'h3
`define IMT_SEL_STAT     3'h4
`define IMT_SEL_SEND     3'h5

`define IMT_CFG_TEN      0
`define IMT_CFG_PLEN     1
`define IMT_CFG_RFMT     2
`define IMT_CFG_WALT     3

`define IMT_SEND_DIR     10
`define IMT_SEND_LEN_LO  11
`define IMT_SEND_SEL_LO  13
`define IMT_SEND_PSEL    15

`define IMT_RES_NONE     2'h0
`define IMT_RES_BUSY     2'h1
`define IMT_RES_ERR      2'h2
`define IMT_RES_OK       2'h3

`define IMT_LEN_THREE    2'h2
`define IMT_TEN_HDR      5'h1e

`define IMT_RST_PTR      16'h0000
`define IMT_RST_TXD      32'h00000000
`define IMT_RST_CFG      4'h0
`define IMT_RST_SEND     16'h0000

`define IMT_CLK_NS       50
`define IMT_QUARTER_NS   2500
`define IMT_QUARTER_CYC  (`IMT_QUARTER_NS / `IMT_CLK_NS)

`endif

// >>> rtl/imt_engine.v
/*
 * two-wire bus master transaction engine with guarded user register access.
 * assumes a single-cycle strobe access port on the same clock, open-drain
 * pads resolved outside, and external pull-ups on both bus lines.
 */
`timescale 1ns/10ps
`default_nettype none
`include "imt_map.vh"

module imt_engine #(
  parameter QCYC = `IMT_QUARTER_CYC  // clock cycles per quarter bit
) (
  input  wire        clock,      // 20 MHz system clock
  input  wire        rst_b,      // async reset, active low
  input  wire        acc_rd,     // user read strobe
  input  wire        acc_wr,     // user write strobe
  input  wire [2:0]  acc_sel,    // register select
  input  wire [31:0] acc_wdata,  // user write data
  input  wire        alert_clr,  // clears summary alert
  input  wire        sda_i,      // data line level
  output reg  [31:0] acc_rdata,  // read data, zero when refused
  output reg         acc_ack,    // access accepted pulse
  output reg         acc_rjct,   // access refused pulse
  output reg         bus_master_summary_alert, // sticky alert
  output reg         xfer_busy,  // transaction active
  output reg         scl_o,      // clock pad output value
  output reg         scl_oe_b,   // clock pad enable, low pulls low
  output reg         sda_o,      // data pad output value
  output reg         sda_oe_b    // data pad enable, low pulls low
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_BIT   = 2'h2;
  localparam ST_STOP  = 2'h3;
  localparam PH_PRE   = 2'h0;
  localparam PH_RXA   = 2'h1;
  localparam PH_RX    = 2'h2;

  reg        rst_m_reg, rst_s_reg;
  reg        sda_m_reg, sda_s_reg;
  reg [15:0] pointer_bytes_register;
  reg [31:0] transmit_data_registers;
  reg [31:0] receive_data_registers;
  reg [3:0]  bus_master_config_register;
  reg [15:0] transfer_launch_register;
  reg [1:0]  transfer_result_field;
  reg        request_reject_flag, dev_nack_reg, data_nack_reg, err_reg;
  reg [1:0]  state_reg, q_reg, ph_reg;
  reg [11:0] div_reg;
  reg [3:0]  bitn_reg, bidx_reg;
  reg [1:0]  rcnt_reg;
  reg [7:0]  sh_reg;
  reg [7:0]  byte_val;
  reg [3:0]  k;

  wire rst_n = rst_s_reg;
  wire ten_bit_address_select = bus_master_config_register[`IMT_CFG_TEN];
  wire pointer_length_select  = bus_master_config_register[`IMT_CFG_PLEN];
  wire read_format_select     = bus_master_config_register[`IMT_CFG_RFMT];
  wire alternate_write_select = bus_master_config_register[`IMT_CFG_WALT];
  wire [9:0] dev_addr = transfer_launch_register[9:0];
  wire transfer_direction_bit = transfer_launch_register[`IMT_SEND_DIR];
  wire [1:0] data_length_field = transfer_launch_register[`IMT_SEND_LEN_LO +: 2];
  wire [1:0] data_sel = transfer_launch_register[`IMT_SEND_SEL_LO +: 2];
  wire ptr_sel = transfer_launch_register[`IMT_SEND_PSEL];

  wire busy = (state_reg != ST_IDLE);
  wire tick = (div_reg == 12'h000);
  wire rx_bit = (ph_reg == PH_RX);

  // byte counts of each part of the transaction
  wire [3:0] naddr = ten_bit_address_select ? 4'h2 : 4'h1;
  wire [3:0] nptr  = (!transfer_direction_bit || read_format_select) ?
                     (pointer_length_select ? 4'h2 : 4'h1) : 4'h0;
  wire zero_wr = alternate_write_select && (data_length_field == `IMT_LEN_THREE);
  wire [3:0] ndat  = (transfer_direction_bit || zero_wr) ? 4'h0 :
                     {2'b00, data_length_field} + 4'h1;
  // a seven-bit normal read has no write portion at all
  wire no_pre = transfer_direction_bit && !read_format_select && !ten_bit_address_select;
  wire [3:0] npre = no_pre ? 4'h0 : naddr + nptr + ndat;
  // slot of the most significant byte; lower slots follow downward
  wire [1:0] top_slot = (data_length_field == 2'h3) ? 2'h3 :
                        (data_length_field == 2'h2) ? 2'h2 :
                        (data_length_field == 2'h1) ? {data_sel[1], 1'b1} : data_sel;
  wire [1:0] rx_slot = top_slot - rcnt_reg;
  wire [7:0] rxa_byte = ten_bit_address_select ?
                        {`IMT_TEN_HDR, dev_addr[9:8], 1'b1} : {dev_addr[6:0], 1'b1};
  wire last_rx = rx_bit && (rcnt_reg == data_length_field);
  wire addr_byte = (ph_reg == PH_RXA) || ((ph_reg == PH_PRE) && (bidx_reg <= naddr));

  // access guard
  wire wr_guarded = (acc_sel == `IMT_SEL_PTR) || (acc_sel == `IMT_SEL_TXD) ||
                    (acc_sel == `IMT_SEL_CFG) || (acc_sel == `IMT_SEL_STAT) ||
                    (acc_sel == `IMT_SEL_SEND);
  wire rej_wr = acc_wr && busy && wr_guarded;
  wire rej_rd = acc_rd && busy && transfer_direction_bit && (acc_sel == `IMT_SEL_RXD);
  wire rej = rej_wr || rej_rd;
  wire ok_wr = acc_wr && !rej_wr;
  wire ok_rd = acc_rd && !rej_rd;
  wire launch = ok_wr && (acc_sel == `IMT_SEL_SEND);

  // bus events on the sampling edge of an acknowledge cycle and at the end of the stop
  // the two sync flops lag the line, so look one quarter after the clock is let go
  wire samp = (state_reg == ST_BIT) && tick && (q_reg == 2'h2);
  wire stop_end = (state_reg == ST_STOP) && tick && (q_reg == 2'h3);
  wire nak_now = samp && (bitn_reg == 4'h8) && !rx_bit && sda_s_reg;
  wire dev_set = nak_now && addr_byte;
  wire dat_set = nak_now && !addr_byte;
  wire stat_rd = ok_rd && (acc_sel == `IMT_SEL_STAT);

  // byte to send from the pre-read part of the sequence
  always @* begin
    k = bidx_reg - naddr;
    if (bidx_reg < naddr) begin
      if (ten_bit_address_select) begin
        byte_val = (bidx_reg == 4'h0) ? {`IMT_TEN_HDR, dev_addr[9:8], 1'b0} : dev_addr[7:0];
      end else begin
        byte_val = {dev_addr[6:0], 1'b0};
      end
    end else if (bidx_reg < naddr + nptr) begin
      if (pointer_length_select) begin
        byte_val = (k == 4'h0) ? pointer_bytes_register[15:8] : pointer_bytes_register[7:0];
      end else begin
        byte_val = ptr_sel ? pointer_bytes_register[15:8] : pointer_bytes_register[7:0];
      end
    end else begin
      k = k - nptr;
      byte_val = transmit_data_registers[(top_slot - k[1:0]) * 8 +: 8];
    end
  end

  // reset release and data line synchronisers
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_reg <= 1'b0;
      rst_s_reg <= 1'b0;
    end else begin
      rst_m_reg <= 1'b1;
      rst_s_reg <= rst_m_reg;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      sda_m_reg <= sda_i;
      sda_s_reg <= sda_m_reg;
    end
  end

  // user access port
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pointer_bytes_register     <= `IMT_RST_PTR;
      transmit_data_registers    <= `IMT_RST_TXD;
      bus_master_config_register <= `IMT_RST_CFG;
      acc_rdata                  <= 32'h00000000;
      acc_ack                    <= 1'b0;
      acc_rjct                   <= 1'b0;
      bus_master_summary_alert   <= 1'b0;
      request_reject_flag        <= 1'b0;
    end else begin
      acc_ack  <= (ok_rd || ok_wr);
      acc_rjct <= rej;
      if (ok_wr && acc_sel == `IMT_SEL_PTR) begin
        pointer_bytes_register <= acc_wdata[15:0];
      end
      if (ok_wr && acc_sel == `IMT_SEL_TXD) begin
        transmit_data_registers <= acc_wdata;
      end
      if (ok_wr && acc_sel == `IMT_SEL_CFG) begin
        bus_master_config_register <= acc_wdata[3:0];
      end
      // a refused read hands back zero, never live content
      if (ok_rd) begin
        case (acc_sel)
          `IMT_SEL_PTR:  acc_rdata <= {16'h0000, pointer_bytes_register};
          `IMT_SEL_TXD:  acc_rdata <= transmit_data_registers;
          `IMT_SEL_RXD:  acc_rdata <= receive_data_registers;
          `IMT_SEL_CFG:  acc_rdata <= {28'h0000000, bus_master_config_register};
          `IMT_SEL_STAT: acc_rdata <= {27'h0000000, data_nack_reg, dev_nack_reg,
                                       request_reject_flag, transfer_result_field};
          `IMT_SEL_SEND: acc_rdata <= {16'h0000, transfer_launch_register};
          default:       acc_rdata <= 32'h00000000;
        endcase
      end else begin
        acc_rdata <= 32'h00000000;
      end
      // set wins over clear on both sticky bits
      if (rej) begin
        request_reject_flag <= 1'b1;
      end else if (stat_rd) begin
        request_reject_flag <= 1'b0;
      end
      if (rej || dev_set || dat_set) begin
        bus_master_summary_alert <= 1'b1;
      end else if (alert_clr) begin
        bus_master_summary_alert <= 1'b0;
      end
    end
  end

  // result field and per-transaction nack flags
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      transfer_result_field <= `IMT_RES_NONE;
      dev_nack_reg          <= 1'b0;
      data_nack_reg         <= 1'b0;
      err_reg               <= 1'b0;
    end else begin
      if (launch) begin
        transfer_result_field <= `IMT_RES_BUSY;
        err_reg               <= 1'b0;
      end else if (stop_end) begin
        transfer_result_field <= err_reg ? `IMT_RES_ERR : `IMT_RES_OK;
      end else if (stat_rd && transfer_result_field != `IMT_RES_BUSY) begin
        transfer_result_field <= `IMT_RES_NONE;
      end
      if (nak_now) begin
        err_reg <= 1'b1;
      end
      if (dev_set) begin
        dev_nack_reg <= 1'b1;
      end else if (launch || stat_rd) begin
        dev_nack_reg <= 1'b0;
      end
      if (dat_set) begin
        data_nack_reg <= 1'b1;
      end else if (launch || stat_rd) begin
        data_nack_reg <= 1'b0;
      end
    end
  end

  // bus sequencer: every bus phase is four quarter-bit steps
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      transfer_launch_register <= `IMT_RST_SEND;
      receive_data_registers   <= 32'h00000000;
      state_reg <= ST_IDLE;
      q_reg     <= 2'h0;
      ph_reg    <= PH_PRE;
      div_reg   <= 12'h000;
      bitn_reg  <= 4'h0;
      bidx_reg  <= 4'h0;
      rcnt_reg  <= 2'h0;
      sh_reg    <= 8'h00;
      xfer_busy <= 1'b0;
      scl_o     <= 1'b0;
      scl_oe_b  <= 1'b1;
      sda_o     <= 1'b0;
      sda_oe_b  <= 1'b1;
    end else begin
      xfer_busy <= launch || (busy && !stop_end);
      if (!busy || tick) begin
        div_reg <= QCYC[11:0] - 12'h001;
      end else begin
        div_reg <= div_reg - 12'h001;
      end
      if (launch) begin
        transfer_launch_register <= acc_wdata[15:0];
        state_reg <= ST_START;
        q_reg     <= 2'h0;
        ph_reg    <= PH_PRE;
        bidx_reg  <= 4'h0;
      end else if (busy && tick) begin
        q_reg <= q_reg + 2'h1;
        case (state_reg)
          ST_START: begin
            case (q_reg)
              2'h0: sda_oe_b <= 1'b1;
              2'h1: scl_oe_b <= 1'b1;
              2'h2: sda_oe_b <= 1'b0;
              default: begin
                scl_oe_b <= 1'b0;
                state_reg <= ST_BIT;
                bitn_reg  <= 4'h0;
                if (ph_reg == PH_PRE && bidx_reg < npre) begin
                  sh_reg   <= byte_val;
                  bidx_reg <= bidx_reg + 4'h1;
                end else begin
                  sh_reg <= rxa_byte;
                  ph_reg <= PH_RXA;
                end
              end
            endcase
          end
          ST_BIT: begin
            case (q_reg)
              2'h0: begin
                if (bitn_reg == 4'h8) begin
                  sda_oe_b <= !(rx_bit && !last_rx);
                end else begin
                  sda_oe_b <= rx_bit ? 1'b1 : sh_reg[7];
                end
              end
              2'h1: scl_oe_b <= 1'b1;
              2'h2: begin
                if (bitn_reg != 4'h8) begin
                  sh_reg <= {sh_reg[6:0], sda_s_reg};
                end
              end
              default: begin
                scl_oe_b <= 1'b0;
                bitn_reg <= bitn_reg + 4'h1;
                if (bitn_reg == 4'h8) begin
                  bitn_reg <= 4'h0;
                  case (ph_reg)
                    PH_PRE: begin
                      if (bidx_reg < npre) begin
                        sh_reg   <= byte_val;
                        bidx_reg <= bidx_reg + 4'h1;
                      end else if (transfer_direction_bit) begin
                        state_reg <= ST_START;
                        ph_reg    <= PH_RXA;
                      end else begin
                        state_reg <= ST_STOP;
                      end
                    end
                    PH_RXA: begin
                      ph_reg   <= PH_RX;
                      rcnt_reg <= 2'h0;
                    end
                    default: begin
                      receive_data_registers[rx_slot * 8 +: 8] <= sh_reg;
                      if (last_rx) begin
                        state_reg <= ST_STOP;
                      end else begin
                        rcnt_reg <= rcnt_reg + 2'h1;
                      end
                    end
                  endcase
                end
              end
            endcase
          end
          ST_STOP: begin
            case (q_reg)
              2'h0: sda_oe_b <= 1'b0;
              2'h1: scl_oe_b <= 1'b1;
              2'h2: sda_oe_b <= 1'b1;
              default: state_reg <= ST_IDLE;
            endcase
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

endmodule // imt_engine

`default_nettype wire

// >>> bench/imt_engine_props.sv
/* checker for the transaction engine: access answers, guarding and bus framing.
   assumes it is bound to the engine and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module imt_engine_props #(
  parameter QCYC = 2  // clock cycles per quarter bit
) (
  input wire logic        clock,      // system clock
  input wire logic        rst_b,      // async reset
  input wire logic        acc_rd,     // read strobe
  input wire logic        acc_wr,     // write strobe
  input wire logic [2:0]  acc_sel,    // register select
  input wire logic [31:0] acc_wdata,  // write data
  input wire logic        alert_clr,  // alert clear
  input wire logic        sda_i,      // data level
  input wire logic [31:0] acc_rdata,  // read data
  input wire logic        acc_ack,    // accepted
  input wire logic        acc_rjct,   // refused
  input wire logic        bus_master_summary_alert, // alert
  input wire logic        xfer_busy,  // active
  input wire logic        scl_o,      // clock value
  input wire logic        scl_oe_b,   // clock enable
  input wire logic        sda_o,      // data value
  input wire logic        sda_oe_b    // data enable
);
  localparam int SB = 3 * QCYC + 4;
  logic rd_dir_reg;
  // direction only moves while idle, so it stays valid for the whole transfer
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b)
      rd_dir_reg <= 1'h0;
    else if (!xfer_busy && acc_wr && acc_sel == 3'h5)
      rd_dir_reg <= acc_wdata[10];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_wr_refused;
    xfer_busy && acc_wr && acc_sel != 3'h2 && acc_sel < 3'h6 |=> acc_rjct && !acc_ack;
  endproperty
  a_wr_refused: assert property (p_wr_refused) else $error("busy write taken");
  property p_rd_allowed;
    xfer_busy && acc_rd && acc_sel != 3'h2 |=> acc_ack;
  endproperty
  a_rd_allowed: assert property (p_rd_allowed) else $error("busy read refused");
  property p_rxd_guard;
    xfer_busy && acc_rd && acc_sel == 3'h2 |=> acc_rjct == rd_dir_reg;
  endproperty
  a_rxd_guard: assert property (p_rxd_guard) else $error("receive read guard");
  property p_reject_alert;
    acc_rjct |-> ##[0:1] bus_master_summary_alert;
  endproperty
  a_reject_alert: assert property (p_reject_alert) else $error("no alert");
  property p_one_answer;
    acc_rd || acc_wr |=> acc_ack ^ acc_rjct;
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("bad answer");
  property p_rdata_zero;
    !acc_ack |-> acc_rdata == 32'h0;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("stray read data");
  property p_launch;
    !xfer_busy && acc_wr && acc_sel == 3'h5 |=> xfer_busy;
  endproperty
  a_launch: assert property (p_launch) else $error("launch ignored");
  property p_idle_released;
    !xfer_busy |-> scl_oe_b && sda_oe_b;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("idle bus driven");
  property p_start;
    $rose(xfer_busy) |-> ##[1:SB] ($fell(sda_oe_b) && scl_oe_b);
  endproperty
  a_start: assert property (p_start) else $error("no start condition");
endmodule // imt_engine_props
bind imt_engine imt_engine_props #(.QCYC(QCYC)) i_imt_engine_props (
  .clock(clock), .rst_b(rst_b), .acc_rd(acc_rd), .acc_wr(acc_wr), .acc_sel(acc_sel),
  .acc_wdata(acc_wdata), .alert_clr(alert_clr), .sda_i(sda_i), .acc_rdata(acc_rdata),
  .acc_ack(acc_ack), .acc_rjct(acc_rjct), .bus_master_summary_alert(bus_master_summary_alert),
  .xfer_busy(xfer_busy), .scl_o(scl_o), .scl_oe_b(scl_oe_b), .sda_o(sda_o), .sda_oe_b(sda_oe_b));
`default_nettype wire

// >>> bench/imt_slave.sv
/* far-side slave model: acknowledges written bytes, answers reads, logs bus items.
   assumes pull-ups on both lines, so a released line reads high. */
`timescale 1ns/10ps
`default_nettype none
module imt_slave (
  input  wire logic scl,      // clock line level
  input  wire logic sda,      // data line level
  input  wire logic nak,      // refuse every acknowledge
  output var  logic sda_oe_b  // low pulls data low
);
  logic [3:0] bc = 4'h0;
  logic [7:0] sh = 8'h0;
  logic [7:0] tx = 8'h0;
  logic [7:0] nb = 8'h0;
  logic       act = 1'h0;
  logic       first = 1'h0;
  logic       rd = 1'h0;
  logic       fin = 1'h0;
  logic [8:0] seen[$];
  initial sda_oe_b = 1'h1;
  always @(negedge sda) if (scl === 1'h1) begin
    seen.push_back(9'h100);
    act = 1'h1;
    bc = 4'hf;  // wraps to bit 0 on the clock fall that ends the start
    first = 1'h1;
    rd = 1'h0;
    fin = 1'h0;
    nb = 8'h0;
  end
  always @(posedge sda) if (scl === 1'h1 && act) begin
    seen.push_back(9'h101);
    act = 1'h0;
  end
  always @(posedge scl) if (act) begin
    if (bc < 8)
      sh = {sh[6:0], sda};
    else if (rd && !first) begin
      seen.push_back({8'h81, sda});
      fin = sda;  // stop driving after the master refuses a byte
    end
  end
  always @(negedge scl) if (act) begin
    sda_oe_b = 1'h1;
    if (bc == 8) begin
      first = 1'h0;
      tx = 8'h5a + nb;
      nb = nb + 8'h1;
    end
    bc = (bc == 8) ? 4'h0 : bc + 4'h1;
    if (bc == 8 && (first || !rd)) begin
      seen.push_back({1'h0, sh});
      if (first)
        rd = sh[0];
      sda_oe_b = nak;
    end else if (rd && !first && !fin && bc < 8)
      sda_oe_b = tx[7 - bc];
  end
endmodule // imt_slave
`default_nettype wire

// >>> bench/imt_engine_tb.sv
/* bench top for the transaction engine: guarded access, write, pointer-only write, combined read and normal read.
   assumes pull-ups on both lines and the slave model on the far side. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end
module imt_engine_tb;
  logic        clock = 1'h0;
  logic        rst_b = 1'h0;
  logic        acc_rd = 1'h0;
  logic        acc_wr = 1'h0;
  logic        alert_clr = 1'h0;
  logic        nak = 1'h0;
  logic [2:0]  acc_sel = 3'h0;
  logic [31:0] acc_wdata = 32'h0;
  logic [31:0] acc_rdata, q;
  logic        acc_ack, acc_rjct, alert, xfer_busy;
  logic        scl_o, scl_oe_b, sda_o, sda_oe_b, sl_oe_b;
  logic [8:0]  exq[$];
  int          failures = 0;
  int          comparisons = 0;
  wire logic   scl = scl_oe_b ? 1'h1 : scl_o;
  wire logic   sda = (sda_oe_b ? 1'h1 : sda_o) & sl_oe_b;
  imt_engine #(.QCYC(2)) i_imt_engine (.clock(clock), .rst_b(rst_b), .acc_rd(acc_rd),
    .acc_wr(acc_wr), .acc_sel(acc_sel), .acc_wdata(acc_wdata), .alert_clr(alert_clr),
    .sda_i(sda), .acc_rdata(acc_rdata), .acc_ack(acc_ack), .acc_rjct(acc_rjct),
    .bus_master_summary_alert(alert), .xfer_busy(xfer_busy), .scl_o(scl_o),
    .scl_oe_b(scl_oe_b), .sda_o(sda_o), .sda_oe_b(sda_oe_b));
  imt_slave i_imt_slave (.scl(scl), .sda(sda), .nak(nak), .sda_oe_b(sl_oe_b));
  always #25 clock = ~clock;
  function automatic logic [31:0] snd(input logic [9:0] a, input logic d,
                                      input logic [1:0] n, input logic [1:0] s, input logic p);
    return {16'h0, p, s, n, d, a};
  endfunction
  task acc(input logic w, input logic [2:0] s, input logic [31:0] d, input logic ok);
    @(negedge clock);
    acc_wr = w;
    acc_rd = !w;
    acc_sel = s;
    acc_wdata = d;
    @(negedge clock);
    acc_wr = 1'h0;
    acc_rd = 1'h0;
    q = acc_rdata;
    `CHK("ack", ok, acc_ack)
    `CHK("reject", !ok, acc_rjct)
  endtask
  task rdc(input logic [2:0] s, input logic [31:0] e);
    acc(1'h0, s, 32'h0, 1'h1);
    `CHK("read data", e, q)
  endtask
  task wait_end(input logic [31:0] st);
    int n;
    n = 0;
    while (xfer_busy !== 1'h0 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    `CHK("busy end", 1'h0, xfer_busy)
    `CHK("bus items", exq.size(), i_imt_slave.seen.size())
    foreach (exq[k]) `CHK("bus item", exq[k], i_imt_slave.seen[k])
    i_imt_slave.seen.delete();
    rdc(3'h4, st);
  endtask
  task end_sim;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clock);
    rst_b = 1'h1;
    repeat (3) @(negedge clock);
    `CHK("scl idle", 1'h1, scl)
    rdc(3'h4, 32'h0);
    acc(1'h1, 3'h0, 32'h12c4, 1'h1);
    acc(1'h1, 3'h1, 32'h44332211, 1'h1);
    acc(1'h1, 3'h3, 32'h0, 1'h1);
    acc(1'h1, 3'h5, snd(10'h050, 0, 2'h1, 2'h2, 0), 1'h1);
    rdc(3'h4, 32'h1);
    for (int s = 0; s < 6; s++)
      if (s != 2) acc(1'h1, s[2:0], 32'hff, 1'h0);
    `CHK("alert", 1'h1, alert)
    rdc(3'h0, 32'h12c4);
    acc(1'h0, 3'h2, 32'h0, 1'h1);
    exq = '{9'h100, 9'h0a0, 9'h0c4, 9'h044, 9'h033, 9'h101};
    wait_end(32'h7);
    rdc(3'h4, 32'h0);
    alert_clr = 1'h1;
    @(negedge clock);
    alert_clr = 1'h0;
    `CHK("alert clear", 1'h0, alert)
    $display("test guarded write done");
    nak = 1'h1;
    acc(1'h1, 3'h5, snd(10'h050, 0, 2'h0, 2'h0, 0), 1'h1);
    exq = '{9'h100, 9'h0a0, 9'h0c4, 9'h011, 9'h101};
    wait_end(32'h1a);
    `CHK("nack alert", 1'h1, alert)
    nak = 1'h0;
    acc(1'h1, 3'h5, snd(10'h050, 0, 2'h0, 2'h0, 0), 1'h1);
    wait_end(32'h3);
    $display("test refused acknowledge done");
    acc(1'h1, 3'h3, 32'hb, 1'h1);
    acc(1'h1, 3'h5, snd(10'h2a5, 0, 2'h2, 2'h0, 0), 1'h1);
    exq = '{9'h100, 9'h0f4, 9'h0a5, 9'h012, 9'h0c4, 9'h101};
    wait_end(32'h3);
    $display("test pointer only write done");
    acc(1'h1, 3'h3, 32'h4, 1'h1);
    acc(1'h1, 3'h5, snd(10'h050, 1, 2'h3, 2'h0, 1), 1'h1);
    acc(1'h0, 3'h2, 32'h0, 1'h0);
    `CHK("refused read", 32'h0, q)
    rdc(3'h3, 32'h4);
    exq = '{9'h100, 9'h0a0, 9'h012, 9'h100, 9'h0a1, 9'h102, 9'h102, 9'h102, 9'h103, 9'h101};
    wait_end(32'h7);
    rdc(3'h2, 32'h5a5b5c5d);
    $display("test combined read done");
    acc(1'h1, 3'h3, 32'h0, 1'h1);
    acc(1'h1, 3'h5, snd(10'h050, 1, 2'h0, 2'h1, 0), 1'h1);
    exq = '{9'h100, 9'h0a1, 9'h103, 9'h101};
    wait_end(32'h3);
    rdc(3'h2, 32'h5a5b5a5d);
    $display("test normal read done");
    acc(1'h1, 3'h3, 32'h1, 1'h1);
    acc(1'h1, 3'h5, snd(10'h2a5, 1, 2'h0, 2'h0, 0), 1'h1);
    exq = '{9'h100, 9'h0f4, 9'h0a5, 9'h100, 9'h0f5, 9'h103, 9'h101};
    wait_end(32'h3);
    rdc(3'h2, 32'h5a5b5a5a);
    $display("test ten-bit normal read done");
    end_sim();
  end
  // seven transfers of at most about 530 cycles each; 40000 cycles leaves wide margin
  initial begin
    #2000000;
    failures++;
    end_sim();
  end
endmodule // imt_engine_tb
`default_nettype wire
